// [rtc_trim_alarm_pkg.sv]
// Constants for the trim and alarm register group of the clock.
// Assumes a 25 MHz system clock and a 32768 Hz oscillator tick pin.
package rtc_trim_alarm_pkg;

    localparam logic [3:0] ADDR_TRIM        = 4'h7;
    localparam logic [3:0] ADDR_WK_MINUTE   = 4'h8;
    localparam logic [3:0] ADDR_WK_HOUR     = 4'h9;
    localparam logic [3:0] ADDR_WK_DAY_MASK = 4'hA;
    localparam logic [3:0] ADDR_DY_MINUTE   = 4'hB;
    localparam logic [3:0] ADDR_DY_HOUR     = 4'hC;
    localparam logic [3:0] ADDR_SCRATCH     = 4'hD;

    localparam int TRIM_SEL_BIT = 7;
    localparam int TRIM_DIR_BIT = 6;
    localparam int TRIM_MAG_MSB = 5;

    localparam logic [7:0] TRIM_RESET     = 8'h00;
    localparam logic [7:0] SCRATCH_RESET  = 8'h00;
    localparam logic [7:0] ALARM_RESET    = 8'h00;
    localparam logic [7:0] MINUTE_MASK    = 8'h7F;
    localparam logic [7:0] HOUR_MASK      = 8'h3F;
    localparam logic [7:0] DAY_MASK_MASK  = 8'h7F;

    localparam logic [6:0] SEC_00 = 7'h00;
    localparam logic [6:0] SEC_20 = 7'h20;
    localparam logic [6:0] SEC_40 = 7'h40;

    localparam int          COUNT_W       = 17;
    localparam logic [16:0] NOMINAL_COUNT = 17'h08000;

    localparam int CLK_PERIOD_NS   = 40;
    localparam int ALARM_DELAY_NS  = 15000;
    localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1
                                   : (ALARM_DELAY_NS / CLK_PERIOD_NS);

endpackage

// [alarm_flag_unit.sv]
// One alarm's flag: delayed set on a fresh match, clear by writing zero.
// Assumes match and control inputs come from logic on clk.
`timescale 1ns/1ps
module alarm_flag_unit #(
    parameter int DELAY_CYC = rtc_trim_alarm_pkg::ALARM_DELAY_CYC
) (
    input  wire logic clk,         // System clock
    input  wire logic rst_n,       // Synchronous reset
    input  wire logic match,       // Time equals programmed alarm
    input  wire logic enable,      // Alarm enable bit
    input  wire logic flag_wr,     // Write strobe to the flag bit
    input  wire logic flag_wdata,  // Value written to the flag bit
    output logic      flag,        // Flag as read back
    output logic      irq_n        // Interrupt, active low
);
    localparam int CW = $clog2(DELAY_CYC + 1);

    logic          match_q, match_d;
    logic          pend_q, pend_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          flag_q, flag_d;
    logic          hit;

    always_comb begin
        hit     = match & enable;
        match_d = hit;
        pend_d  = pend_q;
        cnt_d   = cnt_q;
        flag_d  = flag_q;
        if (hit && !match_q) begin
            pend_d = 1'b1;
            cnt_d  = '0;
        end else if (pend_q) begin
            cnt_d = cnt_q + CW'(1);
        end
        if (flag_wr && !flag_wdata) begin
            flag_d = 1'b0;
        end
        if (pend_q && cnt_q == CW'(DELAY_CYC - 1)) begin
            pend_d = 1'b0;
            flag_d = 1'b1;
        end
        if (!enable) begin
            pend_d = 1'b0;
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_q <= 1'b0;
            pend_q  <= 1'b0;
            cnt_q   <= '0;
            flag_q  <= 1'b0;
        end else begin
            match_q <= match_d;
            pend_q  <= pend_d;
            cnt_q   <= cnt_d;
            flag_q  <= flag_d;
        end
    end

    assign flag  = flag_q & enable;
    assign irq_n = ~flag;
endmodule

// [rtc_trim_alarm_regs.sv]
// Trim, weekly and daily alarm, and scratch registers with the second divider.
// Assumes the serial interface supplies register strobes on clk, and the
// time counters supply current BCD time on clk.
`timescale 1ns/1ps
module rtc_trim_alarm_regs #(
    parameter int ALARM_DELAY = rtc_trim_alarm_pkg::ALARM_DELAY_CYC,
    parameter int SEC_TICKS   = rtc_trim_alarm_pkg::NOMINAL_COUNT
) (
    input  wire logic       clk,                // 25 MHz system clock
    input  wire logic       rst_n,              // Synchronous reset, active low
    input  wire logic       osc_tick,           // 32768 Hz oscillator pin
    input  wire logic       power_on_flag,      // Power-on flag level
    input  wire logic [3:0] reg_addr,           // Register address
    input  wire logic       reg_wr,             // Write strobe
    input  wire logic [7:0] reg_wdata,          // Write data
    input  wire logic       reg_rd,             // Read strobe
    output logic      [7:0] reg_rdata,          // Read data, valid next cycle
    input  wire logic [6:0] cur_second,         // Current BCD second
    input  wire logic [6:0] cur_minute,         // Current BCD minute
    input  wire logic [5:0] cur_hour,           // Current BCD hour
    input  wire logic [2:0] cur_day_of_week,    // Current weekday code
    input  wire logic       divider_clear,      // Seconds counter written
    input  wire logic       weekly_alarm_enable, // Weekly alarm enable
    input  wire logic       daily_alarm_enable, // Daily alarm enable
    input  wire logic       wk_flag_wr,         // Weekly flag write strobe
    input  wire logic       dy_flag_wr,         // Daily flag write strobe
    input  wire logic       flag_wdata,         // Value written to a flag
    output logic            weekly_alarm_flag,  // Weekly flag readback
    output logic            daily_alarm_flag,   // Daily flag readback
    output logic            alarm_irq_out_a_n,  // Weekly interrupt, active low
    output logic            alarm_irq_out_b_n,  // Daily interrupt, active low
    output logic            second_pulse,       // One-cycle pulse per second
    output logic            clk32_out           // 32 kHz output, untrimmed
);
    localparam int CW = rtc_trim_alarm_pkg::COUNT_W;
    // Nominal ticks per second; a smaller value only shortens simulated seconds
    localparam logic [CW-1:0] NOM = CW'(SEC_TICKS);

    // Register file
    logic [7:0] trim_q, trim_d;
    logic [7:0] wk_min_q, wk_min_d;
    logic [7:0] wk_hour_q, wk_hour_d;
    logic [7:0] wk_days_q, wk_days_d;
    logic [7:0] dy_min_q, dy_min_d;
    logic [7:0] dy_hour_q, dy_hour_d;
    logic [7:0] scratch_q, scratch_d;
    logic [7:0] rdata_q, rdata_d;

    function automatic logic [7:0] field_mask(input logic [3:0] a);
        case (a)
            rtc_trim_alarm_pkg::ADDR_WK_MINUTE,
            rtc_trim_alarm_pkg::ADDR_DY_MINUTE:   field_mask = rtc_trim_alarm_pkg::MINUTE_MASK;
            rtc_trim_alarm_pkg::ADDR_WK_HOUR,
            rtc_trim_alarm_pkg::ADDR_DY_HOUR:     field_mask = rtc_trim_alarm_pkg::HOUR_MASK;
            rtc_trim_alarm_pkg::ADDR_WK_DAY_MASK: field_mask = rtc_trim_alarm_pkg::DAY_MASK_MASK;
            default:                              field_mask = 8'hFF;
        endcase
    endfunction

    logic       trim_wr;
    logic [7:0] wmasked;

    always_comb begin
        trim_d    = trim_q;
        wk_min_d  = wk_min_q;
        wk_hour_d = wk_hour_q;
        wk_days_d = wk_days_q;
        dy_min_d  = dy_min_q;
        dy_hour_d = dy_hour_q;
        scratch_d = scratch_q;
        rdata_d   = rdata_q;
        wmasked   = reg_wdata & field_mask(reg_addr);
        trim_wr   = reg_wr && reg_addr == rtc_trim_alarm_pkg::ADDR_TRIM;
        if (reg_wr) begin
            case (reg_addr)
                rtc_trim_alarm_pkg::ADDR_TRIM:        trim_d    = wmasked;
                rtc_trim_alarm_pkg::ADDR_WK_MINUTE:   wk_min_d  = wmasked;
                rtc_trim_alarm_pkg::ADDR_WK_HOUR:     wk_hour_d = wmasked;
                rtc_trim_alarm_pkg::ADDR_WK_DAY_MASK: wk_days_d = wmasked;
                rtc_trim_alarm_pkg::ADDR_DY_MINUTE:   dy_min_d  = wmasked;
                rtc_trim_alarm_pkg::ADDR_DY_HOUR:     dy_hour_d = wmasked;
                rtc_trim_alarm_pkg::ADDR_SCRATCH:     scratch_d = wmasked;
                default: ;
            endcase
        end
        // Power-on wins over a same-cycle write; alarms stay as written
        if (power_on_flag) begin
            trim_d    = rtc_trim_alarm_pkg::TRIM_RESET;
            scratch_d = rtc_trim_alarm_pkg::SCRATCH_RESET;
        end
        if (reg_rd) begin
            case (reg_addr)
                rtc_trim_alarm_pkg::ADDR_TRIM:        rdata_d = trim_q;
                rtc_trim_alarm_pkg::ADDR_WK_MINUTE:   rdata_d = wk_min_q;
                rtc_trim_alarm_pkg::ADDR_WK_HOUR:     rdata_d = wk_hour_q;
                rtc_trim_alarm_pkg::ADDR_WK_DAY_MASK: rdata_d = wk_days_q;
                rtc_trim_alarm_pkg::ADDR_DY_MINUTE:   rdata_d = dy_min_q;
                rtc_trim_alarm_pkg::ADDR_DY_HOUR:     rdata_d = dy_hour_q;
                rtc_trim_alarm_pkg::ADDR_SCRATCH:     rdata_d = scratch_q;
                default:                              rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trim_q    <= rtc_trim_alarm_pkg::TRIM_RESET;
            wk_min_q  <= rtc_trim_alarm_pkg::ALARM_RESET;
            wk_hour_q <= rtc_trim_alarm_pkg::ALARM_RESET;
            wk_days_q <= rtc_trim_alarm_pkg::ALARM_RESET;
            dy_min_q  <= rtc_trim_alarm_pkg::ALARM_RESET;
            dy_hour_q <= rtc_trim_alarm_pkg::ALARM_RESET;
            scratch_q <= rtc_trim_alarm_pkg::SCRATCH_RESET;
            rdata_q   <= 8'h00;
        end else begin
            trim_q    <= trim_d;
            wk_min_q  <= wk_min_d;
            wk_hour_q <= wk_hour_d;
            wk_days_q <= wk_days_d;
            dy_min_q  <= dy_min_d;
            dy_hour_q <= dy_hour_d;
            scratch_q <= scratch_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Oscillator pin synchroniser; s1 is read only by s2
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic osc_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_tick;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_rise  = osc_s2_q & ~osc_s3_q;
    // Output taps the oscillator ahead of the trimmed divider
    assign clk32_out = osc_s2_q;

    // Second divider with trim
    function automatic logic [CW-1:0] trimmed_len(input logic [7:0] t);
        logic [CW-1:0] step;
        step = '0;
        if (t[rtc_trim_alarm_pkg::TRIM_MAG_MSB:1] == 5'h00) begin
            trimmed_len = NOM;
        end else if (!t[rtc_trim_alarm_pkg::TRIM_DIR_BIT]) begin
            step = CW'(t[5:0]) - CW'(1);
            trimmed_len = NOM + (step << 1);
        end else begin
            step = CW'(6'(~t[5:0])) + CW'(1);
            trimmed_len = NOM - (step << 1);
        end
    endfunction

    logic [CW-1:0] div_q, div_d;
    logic          skip_q, skip_d;
    logic          sec_q, sec_d;
    logic          instant;
    logic [CW-1:0] sec_len;

    always_comb begin
        instant = (cur_second == rtc_trim_alarm_pkg::SEC_00) ||
                  (!trim_q[rtc_trim_alarm_pkg::TRIM_SEL_BIT] &&
                   (cur_second == rtc_trim_alarm_pkg::SEC_20 ||
                    cur_second == rtc_trim_alarm_pkg::SEC_40));
        sec_len = (instant && !skip_q) ? trimmed_len(trim_q)
                                       : NOM;
        div_d   = div_q;
        skip_d  = skip_q;
        sec_d   = 1'b0;
        if (divider_clear) begin
            div_d = '0;
        end else if (osc_rise) begin
            if (div_q >= sec_len - CW'(1)) begin
                div_d  = '0;
                sec_d  = 1'b1;
                skip_d = 1'b0;
            end else begin
                div_d = div_q + CW'(1);
            end
        end
        // Write in this cycle wins over the end-of-second clear
        if (trim_wr) begin
            skip_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q  <= '0;
            skip_q <= 1'b0;
            sec_q  <= 1'b0;
        end else begin
            div_q  <= div_d;
            skip_q <= skip_d;
            sec_q  <= sec_d;
        end
    end

    assign second_pulse = sec_q;

    // Alarm compares
    logic wk_match, dy_match;

    always_comb begin
        wk_match = (cur_minute == wk_min_q[6:0]) &&
                   (cur_hour == wk_hour_q[5:0]) &&
                   (cur_day_of_week != 3'h7) &&
                   wk_days_q[cur_day_of_week] &&
                   (wk_days_q[6:0] != 7'h00);
        dy_match = (cur_minute == dy_min_q[6:0]) &&
                   (cur_hour == dy_hour_q[5:0]);
    end

    alarm_flag_unit #(
        .DELAY_CYC (ALARM_DELAY)
    ) u_weekly (
        .clk        (clk),
        .rst_n      (rst_n),
        .match      (wk_match),
        .enable     (weekly_alarm_enable),
        .flag_wr    (wk_flag_wr),
        .flag_wdata (flag_wdata),
        .flag       (weekly_alarm_flag),
        .irq_n      (alarm_irq_out_a_n)
    );

    alarm_flag_unit #(
        .DELAY_CYC (ALARM_DELAY)
    ) u_daily (
        .clk        (clk),
        .rst_n      (rst_n),
        .match      (dy_match),
        .enable     (daily_alarm_enable),
        .flag_wr    (dy_flag_wr),
        .flag_wdata (flag_wdata),
        .flag       (daily_alarm_flag),
        .irq_n      (alarm_irq_out_b_n)
    );
endmodule

// [rtc_trim_alarm_chk.sv]
// Port checker for the trim and alarm register group.
// Assumes binding to rtc_trim_alarm_regs; sees its ports only.
`timescale 1ns/1ps
module rtc_trim_alarm_chk #(
    parameter int ALARM_DELAY = 4
) (
    input wire logic       clk,                 // System clock
    input wire logic       rst_n,               // Synchronous reset
    input wire logic       osc_tick,            // Oscillator pin
    input wire logic [3:0] reg_addr,            // Register address
    input wire logic       reg_rd,              // Read strobe
    input wire logic [7:0] reg_rdata,           // Read data
    input wire logic       weekly_alarm_enable, // Weekly enable
    input wire logic       daily_alarm_enable,  // Daily enable
    input wire logic       wk_flag_wr,          // Weekly flag write
    input wire logic       dy_flag_wr,          // Daily flag write
    input wire logic       flag_wdata,          // Flag write value
    input wire logic       weekly_alarm_flag,   // Weekly flag
    input wire logic       daily_alarm_flag,    // Daily flag
    input wire logic       alarm_irq_out_a_n,   // Weekly interrupt
    input wire logic       alarm_irq_out_b_n,   // Daily interrupt
    input wire logic       clk32_out            // 32 kHz output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_irq_a_follow: assert property (alarm_irq_out_a_n == !weekly_alarm_flag)
        else $error("weekly interrupt differs from its flag");
    chk_irq_b_follow: assert property (alarm_irq_out_b_n == !daily_alarm_flag)
        else $error("daily interrupt differs from its flag");
    chk_wk_flag_off: assert property (!weekly_alarm_enable |-> !weekly_alarm_flag)
        else $error("weekly flag set while disabled");
    chk_dy_flag_off: assert property (!daily_alarm_enable |-> !daily_alarm_flag)
        else $error("daily flag set while disabled");
    chk_wk_clear_cause: assert property ($fell(weekly_alarm_flag) |->
        !weekly_alarm_enable || $past(wk_flag_wr && !flag_wdata))
        else $error("weekly flag fell without a zero write");
    chk_dy_clear_cause: assert property ($fell(daily_alarm_flag) |->
        !daily_alarm_enable || $past(dy_flag_wr && !flag_wdata))
        else $error("daily flag fell without a zero write");
    chk_dy_set_delay: assert property ($rose(daily_alarm_flag) |->
        $past(daily_alarm_enable, ALARM_DELAY))
        else $error("daily flag set too early");
    chk_minute_msb_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) inside {4'h8, 4'hA, 4'hB} |-> reg_rdata[7] == 1'b0)
        else $error("alarm minute or mask bit 7 not zero");
    chk_hour_top_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) inside {4'h9, 4'hC} |-> reg_rdata[7:6] == 2'h0)
        else $error("alarm hour bits 7 to 6 not zero");
    chk_unmapped_zero: assert property ($past(reg_rd) &&
        ($past(reg_addr) < 4'h7 || $past(reg_addr) > 4'hD) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_stands: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_clk32_plain: assert property ($past(rst_n) && $past(rst_n, 2) &&
        $past(rst_n, 3) |-> clk32_out == $past(osc_tick, 2))
        else $error("32 kHz output does not follow oscillator");
endmodule

bind rtc_trim_alarm_regs rtc_trim_alarm_chk #(.ALARM_DELAY(ALARM_DELAY)) u_chk (
    .clk(clk), .rst_n(rst_n), .osc_tick(osc_tick), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .weekly_alarm_enable(weekly_alarm_enable),
    .daily_alarm_enable(daily_alarm_enable), .wk_flag_wr(wk_flag_wr),
    .dy_flag_wr(dy_flag_wr), .flag_wdata(flag_wdata), .weekly_alarm_flag(weekly_alarm_flag),
    .daily_alarm_flag(daily_alarm_flag), .alarm_irq_out_a_n(alarm_irq_out_a_n),
    .alarm_irq_out_b_n(alarm_irq_out_b_n), .clk32_out(clk32_out));

// [osc_source.sv]
// Oscillator stand-in: toggles the tick pin each clock while running.
// Assumes the bench drives run; the pin holds still while stopped.
`timescale 1ns/1ps
module osc_source (
    input  wire logic clk,      // Bench clock
    input  wire logic run,      // Oscillate while high
    output logic      osc_tick  // Tick pin level
);
    initial osc_tick = 1'b0;
    // Fastest rate the two-flop sync can still count, keeps one second short
    always @(negedge clk) begin
        osc_tick <= run ? ~osc_tick : osc_tick;
    end
endmodule

// [tb_rtc_trim_alarm_regs.sv]
// Self-checking bench for the trim and alarm register group.
// Assumes osc_source stands in for the oscillator; bench plays the host.
`timescale 1ns/1ps
module tb_rtc_trim_alarm_regs;
    localparam int DLY = 4;
    // Short nominal second keeps each trimmed second to a few hundred cycles
    localparam int NT  = 256;
    logic       clk = 1'b0, rst_n, run, power_on_flag, reg_wr, reg_rd, divider_clear;
    logic       weekly_alarm_enable, daily_alarm_enable, wk_flag_wr, dy_flag_wr, flag_wdata;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [6:0] cur_second, cur_minute;
    logic [5:0] cur_hour;
    logic [2:0] cur_day_of_week;
    logic       osc_tick, wk_flag, dy_flag, irq_a_n, irq_b_n, second_pulse, clk32_out;
    int         n_errors = 0, n_compared = 0, seed = 35, cycles = 0, cnt;
    int         exp_reg [16];
    logic [7:0] wk_mask [5] = '{8'h00, 8'h08, 8'h08, 8'h7F, 8'h40};
    logic [2:0] wk_day  [5] = '{3'h3, 3'h3, 3'h4, 3'h6, 3'h6};
    logic [5:0] wk_hr   [5] = '{6'h21, 6'h21, 6'h21, 6'h01, 6'h21};
    logic       wk_hit  [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] tv      [4] = '{8'hFE, 8'h07, 8'h87, 8'h41};
    logic [6:0] ts      [4] = '{7'h00, 7'h20, 7'h20, 7'h40};

    osc_source osc (.clk(clk), .run(run), .osc_tick(osc_tick));
    rtc_trim_alarm_regs #(.ALARM_DELAY(DLY), .SEC_TICKS(NT)) dut (
        .clk(clk), .rst_n(rst_n), .osc_tick(osc_tick), .power_on_flag(power_on_flag),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cur_second(cur_second), .cur_minute(cur_minute),
        .cur_hour(cur_hour), .cur_day_of_week(cur_day_of_week),
        .divider_clear(divider_clear), .weekly_alarm_enable(weekly_alarm_enable),
        .daily_alarm_enable(daily_alarm_enable), .wk_flag_wr(wk_flag_wr),
        .dy_flag_wr(dy_flag_wr), .flag_wdata(flag_wdata), .weekly_alarm_flag(wk_flag),
        .daily_alarm_flag(dy_flag), .alarm_irq_out_a_n(irq_a_n),
        .alarm_irq_out_b_n(irq_b_n), .second_pulse(second_pulse), .clk32_out(clk32_out));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: run did not finish", $time);
            final_report();
        end
    end

    function automatic int msk(input int a);
        case (a)
            7, 13:     return 8'hFF;
            8, 10, 11: return 8'h7F;
            9, 12:     return 8'h3F;
            default:   return 0;
        endcase
    endfunction

    // Second length from the trim byte and the second at which it ends
    function automatic int slen(input logic [7:0] t, input logic [6:0] s);
        if (!(s == 7'h00 || (!t[7] && (s == 7'h20 || s == 7'h40))) || t[5:1] == 5'h00)
            return NT;
        if (!t[6])
            return NT + (int'(t[5:0]) - 1) * 2;
        // Invert at six bits before widening
        return NT - (int'(6'(~t[5:0])) + 1) * 2;
    endfunction

    task automatic cmp8(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("Error at %0t: read %h expected %h", $time, g, x);
        end
    endtask

    task automatic cmp1(input logic g, input logic x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("Error at %0t: flag %b expected %b", $time, g, x);
        end
    endtask

    task automatic cmpn(input int g, input int x);
        n_compared++;
        if (g != x) begin
            n_errors++;
            $display("Error at %0t: second of %0d cycles expected %0d", $time, g, x);
        end
    endtask

    // Cycles from the current falling edge to the one that sees the next pulse
    task automatic pulse_gap(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (second_pulse !== 1'b1);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        exp_reg[a] = d & msk(a);
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        cmp8(reg_rdata, 8'(exp_reg[a]));
    endtask

    task automatic fw(input logic wk, input logic v);
        @(negedge clk);
        wk_flag_wr = wk;
        dy_flag_wr = !wk;
        flag_wdata = v;
        @(negedge clk);
        wk_flag_wr = 1'b0;
        dy_flag_wr = 1'b0;
    endtask

    task automatic final_report;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        {rst_n, run, power_on_flag, reg_wr, reg_rd, divider_clear, flag_wdata} = '0;
        {weekly_alarm_enable, daily_alarm_enable, wk_flag_wr, dy_flag_wr} = '0;
        {reg_addr, reg_wdata, cur_second, cur_minute, cur_hour, cur_day_of_week} = '0;
        foreach (exp_reg[i]) exp_reg[i] = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int a = 0; a < 16; a++) rd(4'(a));
        repeat (3) for (int a = 5; a < 16; a++) begin
            wr(4'(a), 8'($random(seed)));
            rd(4'(a));
        end
        wr(4'h7, 8'h5A);
        wr(4'hD, 8'hA5);
        power_on_flag = 1'b1;
        @(negedge clk);
        power_on_flag = 1'b0;
        exp_reg[7] = 0;
        exp_reg[13] = 0;
        for (int a = 7; a < 14; a++) rd(4'(a));
        $display("register tests done");
        wr(4'hB, 8'h59);
        wr(4'hC, 8'h32);
        cur_minute = 7'h59;
        cur_hour = 6'h12;
        daily_alarm_enable = 1'b1;
        repeat (DLY + 6) @(negedge clk);
        cmp1(dy_flag, 1'b0);
        cur_hour = 6'h32;
        repeat (2) @(negedge clk);
        cmp1(dy_flag, 1'b0);
        repeat (DLY + 4) @(negedge clk);
        cmp1(dy_flag, 1'b1);
        cmp1(irq_b_n, 1'b0);
        fw(1'b0, 1'b1);
        cmp1(dy_flag, 1'b1);
        fw(1'b0, 1'b0);
        cmp1(irq_b_n, 1'b1);
        daily_alarm_enable = 1'b0;
        $display("daily alarm tests done");
        wr(4'h8, 8'h30);
        wr(4'h9, 8'h21);
        weekly_alarm_enable = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cur_minute = 7'h00;
            wr(4'hA, wk_mask[i]);
            fw(1'b1, 1'b0);
            cur_minute = 7'h30;
            cur_hour = wk_hr[i];
            cur_day_of_week = wk_day[i];
            repeat (DLY + 6) @(negedge clk);
            cmp1(wk_flag, wk_hit[i]);
            cmp1(irq_a_n, !wk_hit[i]);
        end
        $display("weekly alarm tests done");
        run = 1'b1;
        divider_clear = 1'b1;
        @(negedge clk);
        divider_clear = 1'b0;
        pulse_gap(cnt);
        // Oscillator rises every two cycles, so a second spans twice its ticks
        for (int i = 0; i < 4; i++) begin
            cur_second = ts[i];
            // The write spends two cycles of the second that it lands in
            wr(4'h7, tv[i]);
            pulse_gap(cnt);
            cmpn(cnt + 2, 2 * NT);
            pulse_gap(cnt);
            cmpn(cnt, 2 * slen(tv[i], ts[i]));
        end
        $display("trim test done");
        final_report();
    end
endmodule
